// ==== oca_pkg.sv ====
// Purpose: shared constants and carriers for the osd character attribute block
// Assumes: 32-bit AXI4-Lite register bus, one pixel clock domain
// Notes: register offsets are byte addresses of aligned words
`default_nettype none
package oca_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CURSOR = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CURSOR_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff7f;
  localparam logic [31:0] CURSOR_MASK = 32'h003f_1f03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // control register fields
  localparam int CTL_TTX = 0;
  localparam int CTL_MESH = 1;
  localparam int CTL_BMESH = 2;
  localparam int CTL_CMESH = 3;
  localparam int CTL_SHADOW = 4;
  localparam int CTL_PLANES = 5;
  localparam int CTL_TRANSP = 6;
  localparam int CTL_FRN_N = 8;
  localparam int CTL_FRN_S = 9;
  localparam int CTL_FRN_E = 10;
  localparam int CTL_FRN_W = 11;
  localparam int CTL_FCOL = 12;

  // cursor register fields
  localparam int CUR_ON = 0;
  localparam int CUR_HOLD = 1;
  localparam int CUR_ROW = 8;
  localparam int CUR_COL = 16;
  localparam logic [4:0] CAPT_ROW_MAX = 5'h0f;
  localparam logic [5:0] CAPT_COL_MAX = 6'h2f;
  localparam logic [4:0] TTX_ROW_MAX = 5'h18;
  localparam logic [5:0] TTX_COL_MAX = 6'h27;

  // ----------------------------------------------------------------
  // display word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 12;
  localparam int W_SERIAL = 11;
  localparam int W_SMODE = 10;
  localparam int W_FG = 8;
  localparam int MAX_POSITIONS = 768;
  localparam int SA_UNDER = 4;
  localparam int SA_OVER = 5;
  localparam int SA_BOX = 6;
  localparam int SA_FLASH = 7;
  localparam int SA_ITALIC = 8;
  localparam int SA_FRINGE = 9;
  localparam int SA_HSIZE = 4;
  localparam int SA_VSIZE = 5;
  localparam int SA_BANK = 7;
  localparam int SA_BGDUR = 8;
  localparam int SA_EOR = 9;

  // special graphics live at codes 80h..9fh
  localparam logic [2:0] SPECIAL_PREFIX = 3'h4;
  localparam int SPECIAL_MAX = 16;

  // ----------------------------------------------------------------
  // colour entries and teletext control codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ENT_WHITE = 4'h7;
  localparam logic [3:0] ENT_BLACK_BG = 4'h8;
  localparam logic [3:0] ENT_PLANE_10 = 4'h6;
  localparam logic [3:0] ENT_PLANE_11 = 4'h7;
  localparam logic [7:0] TT_FLASH = 8'h08;
  localparam logic [7:0] TT_STEADY = 8'h09;
  localparam logic [7:0] TT_BOX_END = 8'h0a;
  localparam logic [7:0] TT_BOX_START = 8'h0b;
  localparam logic [7:0] TT_NORMAL = 8'h0c;
  localparam logic [7:0] TT_CONCEAL = 8'h18;
  localparam logic [7:0] TT_CONTIG = 8'h19;
  localparam logic [7:0] TT_SEPARATE = 8'h1a;
  localparam logic [7:0] TT_BLACK_BG = 8'h1c;
  localparam logic [7:0] TT_NEW_BG = 8'h1d;
  localparam logic [7:0] TT_HOLD = 8'h1e;
  localparam logic [7:0] TT_RELEASE = 8'h1f;

  typedef struct packed {
    logic [3:0] fg;
    logic [3:0] bg;
    logic gfx;
    logic separate;
    logic hold_mos;
    logic conceal;
    logic under;
    logic over;
    logic box;
    logic flash;
    logic italic;
    logic fringe;
    logic bank;
    logic bgdur;
    logic eor;
    logic hsize;
    logic vsize;
  } oca_attr_t;

  localparam oca_attr_t ATTR_CAPT_RST = '0;
  localparam oca_attr_t ATTR_TTX_RST = '{fg: ENT_WHITE, bg: ENT_BLACK_BG, default: 1'b0};

  typedef struct packed {
    logic pat;
    logic nb_n;
    logic nb_s;
    logic nb_e;
    logic nb_w;
    logic plane1;
    logic plane0;
    logic x_odd;
    logic line_odd;
    logic top_line;
    logic bot_line;
  } oca_pix_t;

endpackage

`default_nettype wire

// ==== oca_attr_top.sv ====
// Purpose: per-character attribute decode and pixel colour selection
// Assumes: all inputs come from logic on CLK_SYS; colour table lives outside
// Notes: output colour is an entry index; PIX_VIDEO selects live video
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - four fringe directions, fringe colour from register
// - caption fringe from serial mode 0 bit9
// - teletext shadow on alphanumerics only, never graphics
// - mesh alternates pixels, offset each line
// - caption mesh bit meshes every background
// - teletext mesh entry 8 black, 9-15 colour
// - cursor swaps colours at row and column
// - hold bit freezes cursor position
// - caption cursor ranges; cursor stays rectangular
// - up to sixteen specials at 80h-9fh codes
// - specials only while planes bit set
// - no fringe, underline, overline on specials
// - plane pair picks bg, fg, entry 6, 7
// - transparent screen: box shows bg, else video
// - serial attribute set at/after, shown as space
// - caption row start defaults
// - 12-bit sequential words, 768 positions max
// - teletext one attribute per location, row scoped
// - teletext row start defaults
// - bit11 clear: code and foreground colour
// - bit11 set: serial, bit10 picks layout
// - caption foreground bank from latest mode 1 serial
module oca_attr_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [oca_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [oca_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic ROW_START,
  input wire logic [4:0] ROW_NUM,
  input wire logic CHAR_VALID,
  input wire logic [oca_pkg::WORD_W-1:0] DISP_WORD,
  input wire oca_pkg::oca_pix_t PIX_IN,
  output logic [7:0] CHAR_CODE,
  output logic CHAR_SPECIAL,
  output logic [3:0] PIX_COLOUR,
  output logic PIX_VIDEO
);
  import oca_pkg::*;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] cursor_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] status;

  // address and data are taken together, so order of arrival is free
  wire wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  wire rd_go = S_AXI_ARVALID & ~rvalid_q;
  wire wr_ctrl = wr_go & (S_AXI_AWADDR == REG_CTRL);
  wire wr_cursor = wr_go & (S_AXI_AWADDR == REG_CURSOR);
  wire wr_hit = wr_ctrl | wr_cursor | (S_AXI_AWADDR == REG_STATUS);
  wire rd_hit = (S_AXI_ARADDR == REG_CTRL) | (S_AXI_ARADDR == REG_CURSOR) |
                (S_AXI_ARADDR == REG_STATUS);
  wire [31:0] wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                       {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] keep);
    merge = ((old & ~wmask) | (S_AXI_WDATA & wmask)) & keep;
  endfunction

  wire [31:0] rd_mux = (S_AXI_ARADDR == REG_CTRL) ? ctrl_q :
                       (S_AXI_ARADDR == REG_CURSOR) ? cursor_q :
                       (S_AXI_ARADDR == REG_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      cursor_q <= CURSOR_RST;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, CTRL_MASK);
      if (wr_cursor) cursor_q <= merge(cursor_q, CURSOR_MASK);
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
        rdata_q <= rd_mux;
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  wire ttx = ctrl_q[CTL_TTX];
  wire planes_on = ctrl_q[CTL_PLANES];
  wire [3:0] frn_dir = ctrl_q[CTL_FRN_W:CTL_FRN_N];
  wire [3:0] frn_col = ctrl_q[CTL_FCOL+3:CTL_FCOL];

  // ----------------------------------------------------------------
  // cursor position
  // ----------------------------------------------------------------
  logic [4:0] cur_row_q;
  logic [5:0] cur_col_q;
  wire cur_on = cursor_q[CUR_ON];
  wire cur_hold = cursor_q[CUR_HOLD];
  wire [4:0] row_max = ttx ? TTX_ROW_MAX : CAPT_ROW_MAX;
  wire [5:0] col_max = ttx ? TTX_COL_MAX : CAPT_COL_MAX;
  wire cur_valid = (cur_row_q <= row_max) & (cur_col_q <= col_max);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cur_row_q <= 5'h00;
      cur_col_q <= 6'h00;
    end else if (!cur_hold) begin
      cur_row_q <= cursor_q[CUR_ROW+4:CUR_ROW];
      cur_col_q <= cursor_q[CUR_COL+5:CUR_COL];
    end
  end

  // ----------------------------------------------------------------
  // attribute decode per character
  // ----------------------------------------------------------------
  oca_attr_t attr_q;
  oca_attr_t attr_d;
  oca_attr_t cell_d;
  oca_attr_t cell_q;
  logic [7:0] code_d;
  logic space_d;
  logic [5:0] col_q;
  logic [4:0] row_q;
  logic [9:0] pos_q;
  logic first_q;
  logic ended_q;
  logic [5:0] cell_col_q;
  logic [4:0] cell_row_q;
  logic cell_space_q;
  logic cell_blank_q;
  logic [7:0] code_q;

  wire serial = DISP_WORD[W_SERIAL];
  wire smode1 = DISP_WORD[W_SMODE];
  wire [7:0] wcode = DISP_WORD[7:0];
  wire tt_ctl = (wcode[7:5] == 3'h0);

  always_comb begin
    attr_d = attr_q;
    cell_d = attr_q;
    code_d = wcode;
    space_d = 1'b0;
    if (!ttx) begin
      if (serial) begin
        space_d = 1'b1;
        attr_d.bg = DISP_WORD[3:0];
        if (!smode1) begin
          attr_d.under = DISP_WORD[SA_UNDER];
          attr_d.over = DISP_WORD[SA_OVER];
          attr_d.box = DISP_WORD[SA_BOX];
          attr_d.flash = DISP_WORD[SA_FLASH];
          attr_d.italic = DISP_WORD[SA_ITALIC];
          attr_d.fringe = DISP_WORD[SA_FRINGE];
          cell_d = attr_d;
        end else if (first_q) begin
          attr_d.hsize = DISP_WORD[SA_HSIZE];
          attr_d.vsize = DISP_WORD[SA_VSIZE];
          attr_d.box = DISP_WORD[SA_BOX];
          attr_d.bank = DISP_WORD[SA_BANK];
          attr_d.bgdur = DISP_WORD[SA_BGDUR];
          attr_d.eor = DISP_WORD[SA_EOR];
          cell_d = attr_d;
        end else begin
          attr_d.under = DISP_WORD[SA_UNDER];
          attr_d.over = DISP_WORD[SA_OVER];
          attr_d.box = DISP_WORD[SA_BOX];
          attr_d.bank = DISP_WORD[SA_BANK];
          attr_d.bgdur = DISP_WORD[SA_BGDUR];
          attr_d.eor = DISP_WORD[SA_EOR];
          // duration and end of row act here, the rest from the next cell
          cell_d.bgdur = attr_d.bgdur;
          cell_d.eor = attr_d.eor;
        end
      end else begin
        cell_d.fg = {attr_q.bank, DISP_WORD[W_FG+2:W_FG]};
      end
    end else if (tt_ctl) begin
      space_d = 1'b1;
      case (wcode)
        TT_STEADY: begin
          attr_d.flash = 1'b0;
          cell_d.flash = 1'b0;
        end
        TT_NORMAL: begin
          attr_d.hsize = 1'b0;
          attr_d.vsize = 1'b0;
          cell_d.hsize = 1'b0;
          cell_d.vsize = 1'b0;
        end
        TT_CONCEAL: begin
          attr_d.conceal = 1'b1;
          cell_d.conceal = 1'b1;
        end
        TT_CONTIG: begin
          attr_d.separate = 1'b0;
          cell_d.separate = 1'b0;
        end
        TT_SEPARATE: begin
          attr_d.separate = 1'b1;
          cell_d.separate = 1'b1;
        end
        TT_BLACK_BG: begin
          attr_d.bg = ENT_BLACK_BG;
          cell_d.bg = ENT_BLACK_BG;
        end
        TT_NEW_BG: begin
          attr_d.bg = {1'b1, attr_q.fg[2:0]};
          cell_d.bg = {1'b1, attr_q.fg[2:0]};
        end
        TT_HOLD: begin
          attr_d.hold_mos = 1'b1;
          cell_d.hold_mos = 1'b1;
        end
        TT_FLASH: attr_d.flash = 1'b1;
        TT_BOX_START: attr_d.box = 1'b1;
        TT_BOX_END: attr_d.box = 1'b0;
        TT_RELEASE: attr_d.hold_mos = 1'b0;
        default: begin
          // colour codes act from the next cell onward
          if (wcode[7:4] == 4'h0 && !wcode[3]) begin
            attr_d.fg = {1'b0, wcode[2:0]};
            attr_d.gfx = 1'b0;
            attr_d.conceal = 1'b0;
          end else if (wcode[7:4] == 4'h1 && !wcode[3]) begin
            attr_d.fg = {1'b0, wcode[2:0]};
            attr_d.gfx = 1'b1;
            attr_d.conceal = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      attr_q <= ATTR_CAPT_RST;
      cell_q <= ATTR_CAPT_RST;
      col_q <= 6'h00;
      row_q <= 5'h00;
      pos_q <= 10'h000;
      first_q <= 1'b1;
      ended_q <= 1'b0;
      cell_col_q <= 6'h00;
      cell_row_q <= 5'h00;
      cell_space_q <= 1'b1;
      cell_blank_q <= 1'b1;
      code_q <= 8'h00;
    end else if (ROW_START) begin
      attr_q <= ttx ? ATTR_TTX_RST : ATTR_CAPT_RST;
      col_q <= 6'h00;
      row_q <= ROW_NUM;
      first_q <= 1'b1;
      ended_q <= 1'b0;
      if (ROW_NUM == 5'h00) pos_q <= 10'h000;
    end else if (CHAR_VALID) begin
      attr_q <= attr_d;
      cell_q <= cell_d;
      code_q <= code_d;
      cell_space_q <= space_d | ended_q;
      cell_blank_q <= ended_q | (pos_q >= 10'(MAX_POSITIONS));
      cell_col_q <= col_q;
      cell_row_q <= row_q;
      col_q <= col_q + 6'h01;
      if (pos_q < 10'(MAX_POSITIONS)) pos_q <= pos_q + 10'h001;
      first_q <= 1'b0;
      if (!ttx && cell_d.eor) ended_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pixel colour
  // ----------------------------------------------------------------
  logic [3:0] colour_q;
  logic video_q;

  // specials pair two patterns; the plane bits arrive from both at once
  wire special = planes_on & (code_q[7:5] == SPECIAL_PREFIX) &
                 ~cell_space_q & ~cell_blank_q;
  wire cursor_here = cur_on & cur_valid & (cell_row_q == cur_row_q) &
                     (cell_col_q == cur_col_q);
  wire [3:0] fgc = cursor_here ? cell_q.bg : cell_q.fg;
  wire [3:0] bgc = cursor_here ? cell_q.fg : cell_q.bg;
  wire lines = (PIX_IN.top_line & cell_q.over) | (PIX_IN.bot_line & cell_q.under);
  wire pat = PIX_IN.pat & ~cell_space_q & ~cell_q.conceal;
  wire fg_px = pat | (lines & ~special);
  wire frn_attr = ttx ? (ctrl_q[CTL_SHADOW] & ~cell_q.gfx) : cell_q.fringe;
  wire [3:0] nbs = {PIX_IN.nb_w, PIX_IN.nb_e, PIX_IN.nb_s, PIX_IN.nb_n};
  wire frn_px = frn_attr & ~special & ~cell_space_q & ~fg_px &
                (|(nbs & frn_dir));
  wire mesh_ttx = ((cell_q.bg == ENT_BLACK_BG) & ctrl_q[CTL_BMESH]) |
                  ((cell_q.bg > ENT_BLACK_BG) & ctrl_q[CTL_CMESH]);
  wire mesh_on = ttx ? mesh_ttx : ctrl_q[CTL_MESH];
  wire mesh_hole = mesh_on & (PIX_IN.x_odd ^ PIX_IN.line_odd);
  wire transp_bg = ctrl_q[CTL_TRANSP] & ~cell_q.box;
  wire [1:0] plane = {PIX_IN.plane1, PIX_IN.plane0};

  logic [3:0] sp_col;
  logic sp_bg;
  always_comb begin
    sp_bg = 1'b0;
    case (plane)
      2'h0: begin
        sp_col = bgc;
        sp_bg = 1'b1;
      end
      2'h1: sp_col = fgc;
      2'h2: sp_col = ENT_PLANE_10;
      2'h3: sp_col = ENT_PLANE_11;
      default: sp_col = bgc;
    endcase
  end

  wire is_bg = special ? sp_bg : ~(fg_px | frn_px);
  wire [3:0] col_sel = special ? sp_col : fg_px ? fgc : frn_px ? frn_col : bgc;
  // blank cells past the row end keep the background only with duration
  wire blank_video = cell_blank_q & ~(cell_q.bgdur & ~ttx);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      colour_q <= 4'h0;
      video_q <= 1'b1;
    end else begin
      colour_q <= blank_video ? bgc : col_sel;
      video_q <= blank_video | (is_bg & (mesh_hole | transp_bg));
    end
  end

  assign status = {4'h0, cur_col_q, 5'h00, cur_row_q, attr_q.bg, attr_q.fg,
                   1'b0, ended_q, attr_q.fringe, cur_valid & cur_on};
  assign PIX_COLOUR = colour_q;
  assign PIX_VIDEO = video_q;
  assign CHAR_CODE = code_q;
  assign CHAR_SPECIAL = special;

endmodule // oca_attr_top

`default_nettype wire

// ==== oca_attr_chk.sv ====
// Purpose: port-level checks for the osd character attribute block
// Assumes: one pixel clock, synchronous active-high reset
// Notes: bound to every oca_attr_top instance
`timescale 1ns/100ps
`default_nettype none
module oca_attr_chk
  import oca_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic ROW_START,
  input wire logic CHAR_VALID,
  input wire logic [oca_pkg::WORD_W-1:0] DISP_WORD,
  input wire oca_pkg::oca_pix_t PIX_IN,
  input wire logic [7:0] CHAR_CODE,
  input wire logic CHAR_SPECIAL,
  input wire logic [3:0] PIX_COLOUR,
  input wire logic PIX_VIDEO
);
  import oca_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("write not answered");
  a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("read not answered");
  a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_busy_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken while response pending");

  // ------------------------------------------------------------
  // character path
  // ------------------------------------------------------------
  a_code_decode: assert property (CHAR_VALID && !ROW_START && !DISP_WORD[W_SERIAL] |=>
    CHAR_CODE == $past(DISP_WORD[7:0])) else $error("parallel code not decoded");
  a_special_range: assert property (CHAR_SPECIAL |-> CHAR_CODE[7:5] == SPECIAL_PREFIX)
    else $error("special flag outside special codes");
  a_plane_entry: assert property (CHAR_SPECIAL && !CHAR_VALID && !ROW_START && PIX_IN.plane1 |=>
    !PIX_VIDEO && PIX_COLOUR == ($past(PIX_IN.plane0) ? ENT_PLANE_11 : ENT_PLANE_10))
    else $error("plane pair colour wrong");
endmodule // oca_attr_chk

bind oca_attr_top oca_attr_chk chk_u (.CLK_SYS, .RST, .S_AXI_AWVALID, .S_AXI_WVALID,
  .S_AXI_AWREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY, .ROW_START, .CHAR_VALID, .DISP_WORD, .PIX_IN, .CHAR_CODE,
  .CHAR_SPECIAL, .PIX_COLOUR, .PIX_VIDEO);
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the osd character attribute block
// Assumes: 10 MHz pixel clock, inputs driven by non-blocking assignment
// Notes: cursor column counts cells from zero after each row start
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import oca_pkg::*;
  logic clk, rst, awv, wv, bready, arv, rready, row_start, char_valid;
  logic [3:0] awaddr, araddr, pix_colour;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, char_special, pix_video;
  logic [4:0] row_num;
  logic [11:0] disp_word;
  logic [7:0] char_code;
  oca_pix_t pix_in;
  int failures, total_checks;

  oca_attr_top dut_u (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ROW_START(row_start),
    .ROW_NUM(row_num), .CHAR_VALID(char_valid), .DISP_WORD(disp_word), .PIX_IN(pix_in),
    .CHAR_CODE(char_code), .CHAR_SPECIAL(char_special), .PIX_COLOUR(pix_colour),
    .PIX_VIDEO(pix_video));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // bready raised a cycle late so the pending response is seen to stand
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arv <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task automatic row(input logic [4:0] n);
    row_start <= 1'b1;
    row_num <= n;
    @(posedge clk);
    row_start <= 1'b0;
  endtask

  // spare cycle after each cell keeps char_valid single-driven per step
  task automatic put(input logic [11:0] w);
    char_valid <= 1'b1;
    disp_word <= w;
    @(posedge clk);
    char_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pix(input logic pt, input logic [1:0] pl, input logic xo,
    input logic [3:0] ec, input logic ev);
    oca_pix_t p;
    p = '0;
    p.pat = pt;
    p.plane1 = pl[1];
    p.plane0 = pl[0];
    p.x_odd = xo;
    pix_in <= p;
    // at the second edge the first edge's result still stands
    repeat (2) @(posedge clk);
    chk(pix_video, ev);
    if (!ev) begin
      chk(pix_colour, ec);
    end
  endtask

  task automatic frn(input logic [3:0] nb, input logic [3:0] ec);
    oca_pix_t p;
    p = '0;
    {p.nb_w, p.nb_e, p.nb_s, p.nb_n} = nb;
    pix_in <= p;
    repeat (2) @(posedge clk);
    chk(pix_colour, ec);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(REG_CTRL, CTRL_RST, RESP_OKAY);
    rd(REG_CURSOR, CURSOR_RST, RESP_OKAY);
    wr(REG_CTRL, 32'hffff_ffff, RESP_OKAY);
    rd(REG_CTRL, CTRL_MASK, RESP_OKAY);
    wr(REG_CURSOR, 32'hffff_ffff, RESP_OKAY);
    rd(REG_CURSOR, CURSOR_MASK, RESP_OKAY);
    wr(4'hc, 32'h0000_0001, RESP_DECERR);
    wr(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(4'hc, 32'h0, RESP_DECERR);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(REG_CURSOR, 32'h0, RESP_OKAY);
  endtask

  task automatic t_parallel;
    row(5'h00);
    put(12'h5a5);
    chk(char_code, 32'ha5);
    pix(1'b1, 2'b00, 1'b0, 4'h5, 1'b0);
  endtask

  // mode 1 bit 7 is the bank, mode 0 bit 7 is flash only
  task automatic t_bank;
    row(5'h00);
    put(12'hc80);
    put(12'h341);
    pix(1'b1, 2'b00, 1'b0, 4'hb, 1'b0);
    row(5'h00);
    put(12'h341);
    pix(1'b1, 2'b00, 1'b0, 4'h3, 1'b0);
    put(12'h880);
    put(12'h341);
    pix(1'b1, 2'b00, 1'b0, 4'h3, 1'b0);
  endtask

  task automatic t_special;
    wr(REG_CTRL, 32'h20, RESP_OKAY);
    row(5'h00);
    put(12'h185);
    chk(char_special, 32'h1);
    pix(1'b1, 2'b01, 1'b0, 4'h1, 1'b0);
    pix(1'b0, 2'b10, 1'b0, ENT_PLANE_10, 1'b0);
    pix(1'b1, 2'b11, 1'b0, ENT_PLANE_11, 1'b0);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    chk(char_special, 32'h0);
    pix(1'b1, 2'b10, 1'b0, 4'h1, 1'b0);
  endtask

  task automatic t_ttx;
    wr(REG_CTRL, 32'h5, RESP_OKAY);
    row(5'h00);
    put(12'h041);
    pix(1'b1, 2'b00, 1'b0, ENT_WHITE, 1'b0);
    pix(1'b0, 2'b00, 1'b0, ENT_BLACK_BG, 1'b0);
    pix(1'b0, 2'b00, 1'b1, 4'h0, 1'b1);
    wr(REG_CTRL, 32'h9, RESP_OKAY);
    pix(1'b0, 2'b00, 1'b1, ENT_BLACK_BG, 1'b0);
    put(12'h01d);
    pix(1'b0, 2'b00, 1'b1, 4'h0, 1'b1);
    pix(1'b0, 2'b00, 1'b0, 4'hf, 1'b0);
  endtask

  task automatic t_cursor;
    wr(REG_CURSOR, 32'h0000_0001, RESP_OKAY);
    row(5'h00);
    put(12'h041);
    pix(1'b1, 2'b00, 1'b0, ENT_BLACK_BG, 1'b0);
    pix(1'b0, 2'b00, 1'b0, ENT_WHITE, 1'b0);
    wr(REG_CURSOR, 32'h0028_0001, RESP_OKAY);
    row(5'h00);
    put(12'h041);
    pix(1'b1, 2'b00, 1'b0, ENT_WHITE, 1'b0);
    wr(REG_CURSOR, 32'h0000_0001, RESP_OKAY);
    wr(REG_CURSOR, 32'h0028_0003, RESP_OKAY);
    row(5'h00);
    put(12'h041);
    pix(1'b1, 2'b00, 1'b0, ENT_BLACK_BG, 1'b0);
    rd(REG_STATUS, 32'h0000_0871, RESP_OKAY);
  endtask

  // caption fringe from serial mode 0, then teletext shadow on letters only
  task automatic t_fringe;
    wr(REG_CURSOR, 32'h0, RESP_OKAY);
    wr(REG_CTRL, 32'ha100, RESP_OKAY);
    row(5'h00);
    put(12'ha00);
    put(12'h341);
    frn(4'h1, 4'ha);
    frn(4'h2, 4'h0);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    pix(1'b0, 2'b00, 1'b1, 4'h0, 1'b1);
    wr(REG_CTRL, 32'h40, RESP_OKAY);
    pix(1'b0, 2'b00, 1'b0, 4'h0, 1'b1);
    wr(REG_CTRL, 32'ha111, RESP_OKAY);
    row(5'h00);
    put(12'h041);
    frn(4'h1, 4'ha);
    put(12'h011);
    put(12'h041);
    frn(4'h1, ENT_BLACK_BG);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    rst = 1'b1;
    {awv, wv, bready, arv, rready, row_start, char_valid} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    row_num = '0;
    disp_word = '0;
    pix_in = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_parallel;
    t_bank;
    t_special;
    t_ttx;
    t_cursor;
    t_fringe;
    finish_test;
  end

  // under two hundred cycles expected; this allows twenty thousand
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
